// *** rtl/prdac_defines.vh ***
// prdac_defines.vh - constants of the pulse-width / rate-multiplier dac
// assumes: included by bare name from every prdac design file
`ifndef PRDAC_DEFINES_VH
`define PRDAC_DEFINES_VH

// ============================================================
// shared counter layout
`define PRDAC_CNT_W 12
`define PRDAC_PWM_W 6
`define PRDAC_PWM_MSB 5
`define PRDAC_SEQ_LSB 6
`define PRDAC_SEQ_MSB 9
`define PRDAC_PWM_LAST 6'h3F
`define PRDAC_PWM_ZERO 6'h00

// ============================================================
// channel control byte fields
`define PRDAC_CTRL_ONE_BIT 7
`define PRDAC_CTRL_POL_BIT 6
`define PRDAC_CTRL_WGT_MSB 5
`define PRDAC_CTRL_WGT_LSB 0
`define PRDAC_CTRL_RESET 8'h80

// ============================================================
// rate multiplier byte fields, two channels per byte
`define PRDAC_RATE_HI_MSB 7
`define PRDAC_RATE_HI_LSB 4
`define PRDAC_RATE_LO_MSB 3
`define PRDAC_RATE_LO_LSB 0
`define PRDAC_RATE_RESET 8'h00

// ============================================================
// output enable byte
`define PRDAC_OE_RESET 8'h80

`endif

// *** rtl/prdac_chan.v ***
// prdac_chan.v - one output channel: set on wrap, clear on match, widen
// assumes: counter value and widen decision come from prdac_top, same clock
`timescale 1ns/1ps
`include "prdac_defines.vh"

module prdac_chan (
    input wire clk_i,
    input wire rst_n_i,
    input wire [`PRDAC_PWM_MSB:0] pwm_cnt_i,
    input wire widen_next_i,
    input wire [`PRDAC_PWM_MSB:0] weight_i,
    input wire pol_i,
    input wire enable_i,
    output wire raw_o,
    output reg pin_o
);

    reg raw_q;
    reg raw_d;
    wire at_match;
    wire at_wrap;
    wire at_last;

    // compare and wrap decode
    assign at_match = (pwm_cnt_i == weight_i);
    assign at_wrap = (pwm_cnt_i == `PRDAC_PWM_ZERO);
    assign at_last = (pwm_cnt_i == `PRDAC_PWM_LAST);

    // pulse state: widening at count 63 beats the 63 match, setting the pulse one clock early so count 0 of the next period is high
    always @* begin
        raw_d = raw_q;
        if (at_last && widen_next_i) begin
            raw_d = 1'b1;
        end else if (at_match) begin
            raw_d = 1'b0;
        end else if (at_wrap) begin
            raw_d = 1'b1;
        end
    end

    // pulse state register, level and pin move on the same edge
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            raw_q <= 1'b0;
        end else begin
            raw_q <= raw_d;
        end
    end

    assign raw_o = raw_q;

    // pin: polarity applied, gated by enable
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_o <= 1'b0;
        end else begin
            pin_o <= enable_i & (raw_d ^ pol_i);
        end
    end

endmodule // prdac_chan

// *** rtl/prdac_top.v ***
// prdac_top.v - eight-channel 10-bit pulse-width plus rate-multiplier dac
// assumes: one clock, writes come as strobes with data from same-clock logic
`timescale 1ns/1ps
`include "prdac_defines.vh"

module prdac_top #(
    parameter NCH = 8
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire [NCH-1:0] ctrl_wr_i,
    input wire [7:0] ctrl_wdata_i,
    input wire [NCH/2-1:0] rate_wr_i,
    input wire [7:0] rate_wdata_i,
    input wire oe_wr_i,
    input wire [7:0] oe_wdata_i,
    output wire [NCH*8-1:0] ctrl_rdata_o,
    output wire [NCH*4-1:0] rate_rdata_o,
    output wire [7:0] oe_rdata_o,
    output wire [`PRDAC_CNT_W-1:0] count_o,
    output wire [3:0] period_o,
    output wire period_start_o,
    output wire [NCH-1:0] level_o,
    output wire [NCH-1:0] pwm_o
);

    // ============================================================
    // helper functions

    // bit-reverse of the four sequence bits
    function [3:0] seq_rev;
        input [3:0] s;
        begin
            seq_rev = {s[0], s[1], s[2], s[3]};
        end
    endfunction

    // decides whether a period index gets the extra clock
    function widen_sel;
        input [3:0] rate;
        input [3:0] idx;
        reg hit0;
        reg hit1;
        reg hit2;
        reg hit3;
        begin
            hit3 = rate[3] & idx[0]; // odd periods
            hit2 = rate[2] & (idx[1:0] == 2'h2); // 2,6,10,14
            hit1 = rate[1] & (idx[2:0] == 3'h4); // 4,12
            hit0 = rate[0] & (idx[3:0] == 4'h8); // 8 only
            widen_sel = hit0 | hit1 | hit2 | hit3;
        end
    endfunction

    // picks one channel's nibble out of a shared rate byte
    function [3:0] rate_pick;
        input [7:0] b;
        input odd;
        begin
            if (odd) begin
                rate_pick = b[`PRDAC_RATE_HI_MSB:`PRDAC_RATE_HI_LSB];
            end else begin
                rate_pick = b[`PRDAC_RATE_LO_MSB:`PRDAC_RATE_LO_LSB];
            end
        end
    endfunction

    // ============================================================
    // shared free-running counter

    reg [`PRDAC_CNT_W-1:0] cnt_q;
    wire [`PRDAC_CNT_W-1:0] cnt_d;
    wire [`PRDAC_PWM_MSB:0] pwm_cnt;
    wire [3:0] seq_now;
    wire [3:0] seq_next;
    wire [3:0] per_now;
    wire [3:0] per_next;

    // advance every clock, wraps at the top
    assign cnt_d = cnt_q + {{(`PRDAC_CNT_W-1){1'b0}}, 1'b1};

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= {`PRDAC_CNT_W{1'b0}};
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // pulse counter and sequence fields
    assign pwm_cnt = cnt_q[`PRDAC_PWM_MSB:0];
    assign seq_now = cnt_q[`PRDAC_SEQ_MSB:`PRDAC_SEQ_LSB];
    assign seq_next = seq_now + 4'h1;

    // period number seen by the rate decode
    assign per_now = seq_rev(seq_now);
    assign per_next = seq_rev(seq_next);

    // ============================================================
    // configuration registers

    reg [6:0] ctrl_q [0:NCH-1];
    reg [3:0] rate_q [0:NCH-1];
    reg [7:0] oe_q;

    // full-byte reset images, cut to the stored fields on purpose
    localparam [7:0] CTRL_RST = `PRDAC_CTRL_RESET;
    localparam [7:0] RATE_RST = `PRDAC_RATE_RESET;

    // output enable byte
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            oe_q <= `PRDAC_OE_RESET;
        end else if (oe_wr_i) begin
            oe_q <= oe_wdata_i;
        end
    end

    assign oe_rdata_o = oe_q;

    genvar gi;

    // per-channel control bytes and rate fields
    generate
        for (gi = 0; gi < NCH; gi = gi + 1) begin : g_cfg
            // invert bit and weight; bit 7 is not stored
            always @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    ctrl_q[gi] <= CTRL_RST[`PRDAC_CTRL_POL_BIT:0];
                end else if (ctrl_wr_i[gi]) begin
                    ctrl_q[gi] <= ctrl_wdata_i[`PRDAC_CTRL_POL_BIT:0];
                end
            end

            // rate field, even channel low nibble, odd channel high nibble
            if (gi % 2 == 0) begin : g_lo
                always @(posedge clk_i or negedge rst_n_i) begin
                    if (!rst_n_i) begin
                        rate_q[gi] <= RATE_RST[`PRDAC_RATE_LO_MSB:`PRDAC_RATE_LO_LSB];
                    end else if (rate_wr_i[gi/2]) begin
                        rate_q[gi] <= rate_pick(rate_wdata_i, 1'b0);
                    end
                end
            end else begin : g_hi
                always @(posedge clk_i or negedge rst_n_i) begin
                    if (!rst_n_i) begin
                        rate_q[gi] <= RATE_RST[`PRDAC_RATE_HI_MSB:`PRDAC_RATE_HI_LSB];
                    end else if (rate_wr_i[gi/2]) begin
                        rate_q[gi] <= rate_pick(rate_wdata_i, 1'b1);
                    end
                end
            end

            // readback, bit 7 forced high
            assign ctrl_rdata_o[gi*8+7:gi*8] = {1'b1, ctrl_q[gi]};
            assign rate_rdata_o[gi*4+3:gi*4] = rate_q[gi];
        end
    endgenerate

    // ============================================================
    // channel generators

    wire [NCH-1:0] widen_next;

    generate
        for (gi = 0; gi < NCH; gi = gi + 1) begin : g_ch
            // widen decision for the period about to start
            assign widen_next[gi] = widen_sel(rate_q[gi], per_next);

            // 6-bit weight and 4-bit rate form the 10-bit value
            prdac_chan u_chan (
                .clk_i(clk_i),
                .rst_n_i(rst_n_i),
                .pwm_cnt_i(pwm_cnt),
                .widen_next_i(widen_next[gi]),
                .weight_i(ctrl_q[gi][`PRDAC_CTRL_WGT_MSB:`PRDAC_CTRL_WGT_LSB]),
                .pol_i(ctrl_q[gi][`PRDAC_CTRL_POL_BIT]),
                .enable_i(oe_q[gi]),
                .raw_o(level_o[gi]),
                .pin_o(pwm_o[gi])
            );
        end
    endgenerate

    // ============================================================
    // status outputs

    assign count_o = cnt_q;
    assign period_o = per_now;
    assign period_start_o = (pwm_cnt == `PRDAC_PWM_ZERO);

endmodule // prdac_top

// *** testbench/prdac_top_sva.sv ***
// prdac_top_sva.sv - port checker for the dac, channel 0 in detail
// assumes: bound into prdac_top, one clock, async active-low reset
`timescale 1ns/1ps
module prdac_top_sva #(
    parameter NCH = 8
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire [NCH-1:0] ctrl_wr_i,
    input wire [7:0] ctrl_wdata_i,
    input wire [NCH*8-1:0] ctrl_rdata_o,
    input wire [NCH*4-1:0] rate_rdata_o,
    input wire [7:0] oe_rdata_o,
    input wire [11:0] count_o,
    input wire [3:0] period_o,
    input wire period_start_o,
    input wire [NCH-1:0] level_o,
    input wire [NCH-1:0] pwm_o
);
    // ==========
    // channel 0 fields, widen decision for the coming period
    wire [5:0] c6 = count_o[5:0];
    wire [5:0] wt = ctrl_rdata_o[5:0];
    wire inv = ctrl_rdata_o[6];
    wire en = oe_rdata_o[0];
    wire [3:0] rt = rate_rdata_o[3:0];
    wire [3:0] nx = count_o[9:6] + 4'h1;
    wire [3:0] p = {nx[0], nx[1], nx[2], nx[3]};
    wire wid = (rt[3] & p[0]) | (rt[2] & (p[1:0] == 2'h2)) | (rt[1] & (p[2:0] == 3'h4))
        | (rt[0] & (p == 4'h8));
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // ==========
    // assertions
    chk_count_step: assert property (
        $past(rst_n_i) |-> count_o == $past(count_o) + 12'h001)
        else $error("counter did not step by one");
    chk_period_rev: assert property (
        period_o == {count_o[6], count_o[7], count_o[8], count_o[9]})
        else $error("period index not bit-reversed");
    chk_start_flag: assert property (period_start_o == (c6 == 6'h00))
        else $error("period start flag wrong");
    chk_ctrl_write: assert property (
        ctrl_wr_i[0] |=> ctrl_rdata_o[7:0] == (8'h80 | ($past(ctrl_wdata_i) & 8'h7F)))
        else $error("control byte readback wrong");
    chk_off_low: assert property (!en ##1 !en |-> !pwm_o[0])
        else $error("disabled pin not low");
    chk_match_low: assert property (
        en && c6 == wt && !(c6 == 6'h3F && wid) ##1 $stable(inv) && en |-> pwm_o[0] == inv)
        else $error("pin not cleared on weight match");
    chk_wrap_high: assert property (
        en && c6 == 6'h00 && wt != 6'h00 ##1 $stable(inv) && en |-> pwm_o[0] == !inv)
        else $error("pin not set on wrap");
    chk_widen_high: assert property (
        en && c6 == 6'h3F && wid ##1 $stable(inv) && en |-> pwm_o[0] == !inv)
        else $error("pin not widened in selected period");
    chk_level_pin: assert property (
        en ##1 $stable(inv) |-> pwm_o[0] == (level_o[0] ^ inv))
        else $error("pin differs from level with polarity applied");
endmodule // prdac_top_sva

// *** testbench/prdac_rc_filter.sv ***
// prdac_rc_filter.sv - rc filter stand-in: tallies high cycles per pin
// assumes: pins sampled on the dac clock, clear_i restarts every tally
`timescale 1ns/1ps
module prdac_rc_filter #(
    parameter NCH = 8
) (
    input wire clk_i,
    input wire clear_i,
    input wire [NCH-1:0] pin_i,
    output logic [NCH*11-1:0] charge_o
);
    // ==========
    // charge integration, one tally per pin
    always @(posedge clk_i) begin
        for (int i = 0; i < NCH; i++) begin
            charge_o[i*11 +: 11] <= clear_i ? 11'h000 : charge_o[i*11 +: 11] + {10'h000, pin_i[i]};
        end
    end
endmodule // prdac_rc_filter

// *** testbench/prdac_top_bench.sv ***
// prdac_top_bench.sv - top testbench of the dac
// assumes: prdac_top, prdac_rc_filter and prdac_top_sva compiled before
`timescale 1ns/1ps
module prdac_top_bench;
    logic clk_i = 1'b0, rst_n_i = 1'b0, oe_wr_i = 1'b0, clr = 1'b0;
    logic [7:0] ctrl_wr_i = '0, ctrl_wdata_i = '0, rate_wdata_i = '0, oe_wdata_i = '0;
    logic [3:0] rate_wr_i = '0;
    logic [63:0] ctrl_rdata_o;
    logic [31:0] rate_rdata_o;
    logic [7:0] oe_rdata_o, pwm_o;
    logic [87:0] charge;
    logic [5:0] wt_t [0:7] = '{6'h3F, 6'h00, 6'h00, 6'h18, 6'h05, 6'h05, 6'h05, 6'h05};
    logic [3:0] rt_t [0:7] = '{4'hF, 4'h0, 4'h0, 4'h6, 4'h1, 4'h2, 4'h4, 4'h8};
    logic [7:0] inv_t = 8'h82;
    int n_errors = 0, n_checks = 0, cyc = 0;
    prdac_top i_dut (.clk_i, .rst_n_i, .ctrl_wr_i, .ctrl_wdata_i, .rate_wr_i, .rate_wdata_i,
        .oe_wr_i, .oe_wdata_i, .ctrl_rdata_o, .rate_rdata_o, .oe_rdata_o, .count_o(),
        .period_o(), .period_start_o(), .level_o(), .pwm_o);
    prdac_rc_filter i_rc (.clk_i, .clear_i(clr), .pin_i(pwm_o), .charge_o(charge));
    // ==========
    // clock, timeout
    initial forever #2 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            summarize();
        end
    end
    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    // one strobe write: kind 0 control, 1 rate, 2 enable
    task automatic wr(input int kind, input int idx, input logic [7:0] d);
        @(posedge clk_i);
        if (kind == 0) ctrl_wr_i <= 8'h01 << idx;
        if (kind == 1) rate_wr_i <= 4'h1 << idx;
        if (kind == 2) oe_wr_i <= 1'b1;
        ctrl_wdata_i <= d;
        rate_wdata_i <= d;
        oe_wdata_i <= d;
        @(posedge clk_i);
        ctrl_wr_i <= '0;
        rate_wr_i <= '0;
        oe_wr_i <= 1'b0;
    endtask
    // tally one full 1024-cycle sequence per pin
    task automatic measure(input logic [7:0] oe);
        logic [11:0] e;
        repeat (64) @(posedge clk_i);
        clr <= 1'b1;
        @(posedge clk_i);
        clr <= 1'b0;
        repeat (1024) @(posedge clk_i);
        #1;
        for (int i = 0; i < 8; i++) begin
            e = {2'b00, wt_t[i], rt_t[i]};
            if (inv_t[i]) e = 12'h400 - e;
            if (!oe[i]) e = 12'h000;
            chk("charge", e, {1'b0, charge[i*11 +: 11]});
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // ==========
    // tests
    initial begin
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        #1;
        for (int i = 0; i < 8; i++) begin
            chk("ctrl reset", 12'h080, {4'h0, ctrl_rdata_o[i*8 +: 8]});
            chk("rate reset", 12'h000, {8'h00, rate_rdata_o[i*4 +: 4]});
        end
        chk("oe reset", 12'h080, {4'h0, oe_rdata_o});
        $display("test reset done");
        for (int i = 0; i < 8; i++) wr(0, i, {1'b0, inv_t[i], wt_t[i]});
        for (int k = 0; k < 4; k++) wr(1, k, {rt_t[2*k+1], rt_t[2*k]});
        wr(2, 0, 8'hFF);
        #1;
        for (int i = 0; i < 8; i++) begin
            chk("ctrl", {5'h01, inv_t[i], wt_t[i]}, {4'h0, ctrl_rdata_o[i*8 +: 8]});
            chk("rate", {8'h00, rt_t[i]}, {8'h00, rate_rdata_o[i*4 +: 4]});
        end
        measure(8'hFF);
        $display("test levels done");
        wr(2, 0, 8'h7E);
        measure(8'h7E);
        $display("test enable done");
        summarize();
    end
endmodule // prdac_top_bench
bind prdac_top prdac_top_sva #(.NCH(NCH)) i_sva (.clk_i, .rst_n_i, .ctrl_wr_i, .ctrl_wdata_i,
    .ctrl_rdata_o, .rate_rdata_o, .oe_rdata_o, .count_o, .period_o, .period_start_o, .level_o,
    .pwm_o);
